// [design/fifo_ctl_defs.svh]
// Constants for the FIFO reset, retransmit and mode-capture controller.
`ifndef FIFO_CTL_DEFS_SVH
`define FIFO_CTL_DEFS_SVH

`define DATA_W           18
`define NARROW_W         9
`define DEPTH            16
`define PTR_W            4
`define CNT_W            5
`define HALF_LEVEL       6'h08
`define FALL_THROUGH_MODE_LATENCY     2'h3
`define RT_SETUP_CYCLES  2'h3
`define AE_OFS_DEFAULT   5'h02
`define AF_OFS_DEFAULT   5'h02
`define PINS_W           32
`define PINS_IDLE        32'hFE000000
`define WB_ADR_W         8
`define ADR_OFFSETS      8'h00
`define ADR_STATUS       8'h04
`define OFS_AE_LSB       0
`define OFS_AF_LSB       8

`endif

// [design/fifo_ctl_pkg.sv]
// Types shared by the FIFO reset and retransmit controller.
`include "fifo_ctl_defs.svh"

package fifo_ctl_pkg;

   typedef struct packed {
      logic                master_reset_n;
      logic                partial_reset_n;
      logic                write_enable_n;
      logic                read_enable_n;
      logic                retransmit_n;
      logic                serial_load_enable_n;
      logic                offset_load_n;
      logic                fallthrough_select_serial_in;
      logic                read_port_width;
      logic                write_port_width;
      logic                byte_order_select;
      logic                retransmit_latency_select;
      logic                flag_timing_select;
      logic                parity_interleave_select;
      logic [`DATA_W-1:0]  write_data;
   } pins_t;

   typedef struct packed {
      logic fall_through_mode;
      logic read_narrow;
      logic write_narrow;
      logic byte_order;
      logic normal_latency;
      logic sync_flag_timing;
      logic parity_interleave;
      logic serial_program;
   } cfg_t;

   typedef enum logic [0:0] {
      RT_RUN,
      RT_SETUP
   } rt_state_t;

   typedef struct packed {
      logic [`DEPTH-1:0][`DATA_W-1:0] mem;
      cfg_t                           cfg;
      logic                           cfg_valid;
      rt_state_t                      rts;
      logic [1:0]                     rt_cnt;
      logic [1:0]                     fw_cnt;
      logic [`PTR_W:0]                wr_ptr;
      logic [`PTR_W:0]                rd_ptr;
      logic                           out_valid;
      logic [`DATA_W-1:0]             dout;
      logic [`CNT_W-1:0]              ae_ofs;
      logic [`CNT_W-1:0]              af_ofs;
      logic                           ofs_wsel;
      logic                           ofs_rsel;
      logic                           ef_n;
      logic                           ov_n;
      logic                           ff_n;
      logic                           is_n;
      logic                           ae_n;
      logic                           af_n;
      logic                           hf_n;
      logic                           ae_lvl;
      logic                           af_lvl;
      logic                           wb_ack;
      logic [31:0]                    wb_dat;
   } state_t;

endpackage : fifo_ctl_pkg

// [design/pin_sync.sv]
// Two-flop synchroniser for a bundle of asynchronous pins.
`timescale 1ns/1ps

module pin_sync #(
   parameter int          W         = 1,
   parameter logic [W-1:0] RESET_VAL = '0
) (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] sync_o
);

   logic [W-1:0] meta_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_q <= RESET_VAL;
         sync_o <= RESET_VAL;
      end else begin
         meta_q <= async_i;
         sync_o <= meta_q;
      end
   end

endmodule : pin_sync

// [design/fifo_reset_retransmit_control.sv]
// FIFO with master reset, partial reset, retransmit and mode capture, Wishbone status.
//
// Design decisions made here: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
`include "fifo_ctl_defs.svh"

module fifo_reset_retransmit_control (
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   input  wire logic                 master_reset_n_i,
   input  wire logic                 partial_reset_n_i,
   input  wire logic                 write_enable_n_i,
   input  wire logic                 read_enable_n_i,
   input  wire logic                 retransmit_n_i,
   input  wire logic                 serial_load_enable_n_i,
   input  wire logic                 offset_load_n_i,
   input  wire logic                 fallthrough_select_serial_in_i,
   input  wire logic                 read_port_width_i,
   input  wire logic                 write_port_width_i,
   input  wire logic                 byte_order_select_i,
   input  wire logic                 retransmit_latency_select_i,
   input  wire logic                 flag_timing_select_i,
   input  wire logic                 parity_interleave_select_i,
   input  wire logic [`DATA_W-1:0]   write_data_i,
   output logic      [`DATA_W-1:0]   read_data_out_o,
   output logic                      empty_flag_n_o,
   output logic                      output_valid_n_o,
   output logic                      full_flag_n_o,
   output logic                      input_space_n_o,
   output logic                      almost_empty_n_o,
   output logic                      almost_full_n_o,
   output logic                      half_full_n_o,
   input  wire logic                 wb_cyc_i,
   input  wire logic                 wb_stb_i,
   input  wire logic                 wb_we_i,
   input  wire logic [`WB_ADR_W-1:0] wb_adr_i,
   input  wire logic [3:0]           wb_sel_i,
   input  wire logic [31:0]          wb_dat_i,
   output logic      [31:0]          wb_dat_o,
   output logic                      wb_ack_o
);

   fifo_ctl_pkg::pins_t  pins_raw;
   fifo_ctl_pkg::pins_t  pins_s;
   logic [`PINS_W-1:0]   pins_s_bits;
   fifo_ctl_pkg::state_t st_q;
   fifo_ctl_pkg::state_t st_d;

   assign pins_raw = '{
      master_reset_n:               master_reset_n_i,
      partial_reset_n:              partial_reset_n_i,
      write_enable_n:               write_enable_n_i,
      read_enable_n:                read_enable_n_i,
      retransmit_n:                 retransmit_n_i,
      serial_load_enable_n:         serial_load_enable_n_i,
      offset_load_n:                offset_load_n_i,
      fallthrough_select_serial_in: fallthrough_select_serial_in_i,
      read_port_width:              read_port_width_i,
      write_port_width:             write_port_width_i,
      byte_order_select:            byte_order_select_i,
      retransmit_latency_select:    retransmit_latency_select_i,
      flag_timing_select:           flag_timing_select_i,
      parity_interleave_select:     parity_interleave_select_i,
      write_data:                   write_data_i
   };

   // Data passes through the same two flops as the enables.
   // A word and its strobe therefore reach the logic in the same cycle.
   pin_sync #(
      .W         (`PINS_W),
      .RESET_VAL (`PINS_IDLE)
   ) u_pin_sync (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .async_i (pins_raw),
      .sync_o  (pins_s_bits)
   );

   assign pins_s = fifo_ctl_pkg::pins_t'(pins_s_bits);

   // Output word as seen on the read port; a narrow port leaves the upper bits at zero.
   function automatic logic [`DATA_W-1:0] fit_out(input logic narrow,
                                                  input logic [`DATA_W-1:0] w);
      fit_out = narrow ? {{(`DATA_W-`NARROW_W){1'b0}}, w[`NARROW_W-1:0]} : w;
   endfunction : fit_out

   always_comb begin
      logic [`CNT_W-1:0] cnt_cur;
      logic [`CNT_W-1:0] cnt_nxt;
      logic [5:0]        total;
      logic              rt_hit;
      logic              full_cur;
      logic              ae_calc;
      logic              af_calc;
      logic              flags_forced;
      logic [`DATA_W-1:0] wdata;
      cnt_cur      = st_q.wr_ptr - st_q.rd_ptr;
      cnt_nxt      = '0;
      total        = '0;
      rt_hit       = 1'b0;
      full_cur     = (cnt_cur == `CNT_W'(`DEPTH));
      ae_calc      = 1'b0;
      af_calc      = 1'b0;
      flags_forced = 1'b0;
      // A narrow write port stores only the low nine bits and keeps the rest at zero.
      wdata        = st_q.cfg.write_narrow ?
                     {{(`DATA_W-`NARROW_W){1'b0}}, pins_s.write_data[`NARROW_W-1:0]} :
                     pins_s.write_data;
      st_d        = st_q;
      st_d.wb_ack = 1'b0;

      if (!pins_s.master_reset_n) begin
         // Straps are taken on every low cycle; the last one before release wins.
         st_d.cfg.sync_flag_timing  = pins_s.flag_timing_select;
         st_d.cfg.normal_latency    = pins_s.retransmit_latency_select;
         st_d.cfg.fall_through_mode = pins_s.fallthrough_select_serial_in;
         st_d.cfg.read_narrow       = pins_s.read_port_width;
         st_d.cfg.write_narrow      = pins_s.write_port_width;
         st_d.cfg.byte_order        = pins_s.byte_order_select;
         st_d.cfg.parity_interleave = pins_s.parity_interleave_select;
         st_d.cfg.serial_program    = pins_s.offset_load_n;
         st_d.cfg_valid             = 1'b1;
         st_d.ae_ofs                = `AE_OFS_DEFAULT;
         st_d.af_ofs                = `AF_OFS_DEFAULT;
         st_d.ofs_wsel              = 1'b0;
         st_d.ofs_rsel              = 1'b0;
         st_d.wr_ptr                = '0;
         st_d.rd_ptr                = '0;
         st_d.dout                  = '0;
         st_d.out_valid             = 1'b0;
         st_d.rts                   = fifo_ctl_pkg::RT_RUN;
         st_d.rt_cnt                = '0;
         st_d.fw_cnt                = '0;
         st_d.ae_n                  = 1'b0;
         st_d.af_n                  = 1'b1;
         st_d.hf_n                  = 1'b1;
         st_d.ov_n                  = 1'b1;
         st_d.is_n                  = !pins_s.fallthrough_select_serial_in;
         st_d.ef_n                  = pins_s.fallthrough_select_serial_in;
         st_d.ff_n                  = 1'b1;
         flags_forced               = 1'b1;
      end else if (!pins_s.partial_reset_n) begin
         // Configuration and offsets stay as they are.
         st_d.wr_ptr    = '0;
         st_d.rd_ptr    = '0;
         st_d.dout      = '0;
         st_d.out_valid = 1'b0;
         st_d.rts       = fifo_ctl_pkg::RT_RUN;
         st_d.rt_cnt    = '0;
         st_d.fw_cnt    = '0;
         st_d.ae_n      = 1'b0;
         st_d.af_n      = 1'b1;
         st_d.hf_n      = 1'b1;
         st_d.ov_n      = 1'b1;
         st_d.is_n      = !st_q.cfg.fall_through_mode;
         st_d.ef_n      = st_q.cfg.fall_through_mode;
         st_d.ff_n      = 1'b1;
         flags_forced   = 1'b1;
      end else if (st_q.cfg_valid) begin
         // Write side.
         if (!pins_s.offset_load_n && !st_q.cfg.serial_program && !pins_s.write_enable_n) begin
            // Parallel offset writes alternate, the empty offset first.
            if (st_q.ofs_wsel) begin
               st_d.af_ofs = wdata[`CNT_W-1:0];
            end else begin
               st_d.ae_ofs = wdata[`CNT_W-1:0];
            end
            st_d.ofs_wsel = !st_q.ofs_wsel;
         end else if (!pins_s.offset_load_n && st_q.cfg.serial_program &&
                      !pins_s.serial_load_enable_n) begin
            // Serial bits enter the empty offset at the bottom and move up into the full one.
            {st_d.af_ofs, st_d.ae_ofs} = {st_q.af_ofs[`CNT_W-2:0], st_q.ae_ofs,
                                          pins_s.fallthrough_select_serial_in};
         end else if (!pins_s.write_enable_n && !full_cur) begin
            st_d.mem[st_q.wr_ptr[`PTR_W-1:0]] = wdata;
            st_d.wr_ptr = st_q.wr_ptr + 1'b1;
         end

         // Read side.
         if (!pins_s.retransmit_n) begin
            // Each low cycle restarts the rewind; a long pulse only stretches it.
            rt_hit         = 1'b1;
            st_d.rd_ptr    = '0;
            st_d.out_valid = 1'b0;
            st_d.fw_cnt    = '0;
            // Zero latency loads the first word on the retransmit edge itself.
            if (!st_q.cfg.normal_latency) begin
               st_d.rts = fifo_ctl_pkg::RT_RUN;
               if (st_q.wr_ptr != '0) begin
                  st_d.dout      = fit_out(st_q.cfg.read_narrow, st_q.mem[0]);
                  st_d.rd_ptr    = `PTR_W'(1) + (`PTR_W+1)'(0);
                  st_d.out_valid = st_q.cfg.fall_through_mode;
               end
            end else begin
               st_d.rts    = fifo_ctl_pkg::RT_SETUP;
               st_d.rt_cnt = '0;
            end
         end else if (st_q.rts == fifo_ctl_pkg::RT_SETUP) begin
            // The empty indication stays forced until the setup count expires.
            if (st_q.rt_cnt == `RT_SETUP_CYCLES - 2'h1) begin
               st_d.rts    = fifo_ctl_pkg::RT_RUN;
               st_d.rt_cnt = '0;
               if (st_q.cfg.fall_through_mode && st_q.wr_ptr != '0) begin
                  st_d.dout      = fit_out(st_q.cfg.read_narrow, st_q.mem[0]);
                  st_d.rd_ptr    = `PTR_W'(1) + (`PTR_W+1)'(0);
                  st_d.out_valid = 1'b1;
               end
            end else begin
               st_d.rt_cnt = st_q.rt_cnt + 2'h1;
            end
         end else if (!pins_s.read_enable_n && !pins_s.offset_load_n) begin
            // Offset reads alternate between the empty and the full offset.
            st_d.dout     = st_q.ofs_rsel ?
                            `DATA_W'(st_q.af_ofs) : `DATA_W'(st_q.ae_ofs);
            st_d.ofs_rsel = !st_q.ofs_rsel;
         end else if (st_q.cfg.fall_through_mode) begin
            // The first word falls through by itself after the fixed latency.
            // Later words wait for a read enable.
            if (!st_q.out_valid) begin
               if (cnt_cur != '0) begin
                  if (st_q.fw_cnt == `FALL_THROUGH_MODE_LATENCY - 2'h1) begin
                     st_d.dout = fit_out(st_q.cfg.read_narrow,
                                         st_q.mem[st_q.rd_ptr[`PTR_W-1:0]]);
                     st_d.rd_ptr    = st_q.rd_ptr + 1'b1;
                     st_d.out_valid = 1'b1;
                     st_d.fw_cnt    = '0;
                  end else begin
                     st_d.fw_cnt = st_q.fw_cnt + 2'h1;
                  end
               end else begin
                  st_d.fw_cnt = '0;
               end
            end else if (!pins_s.read_enable_n) begin
               if (cnt_cur != '0) begin
                  st_d.dout = fit_out(st_q.cfg.read_narrow,
                                      st_q.mem[st_q.rd_ptr[`PTR_W-1:0]]);
                  st_d.rd_ptr = st_q.rd_ptr + 1'b1;
               end else begin
                  st_d.out_valid = 1'b0;
               end
            end
         end else if (!pins_s.read_enable_n && cnt_cur != '0) begin
            st_d.dout = fit_out(st_q.cfg.read_narrow,
                                st_q.mem[st_q.rd_ptr[`PTR_W-1:0]]);
            st_d.rd_ptr = st_q.rd_ptr + 1'b1;
         end
      end

      // Software may also set the offsets; it wins over the pins in the same cycle.
      if (wb_cyc_i && wb_stb_i && !st_q.wb_ack) begin
         st_d.wb_ack = 1'b1;
         st_d.wb_dat = '0;
         if (wb_we_i && {wb_adr_i[`WB_ADR_W-1:2], 2'b00} == `ADR_OFFSETS) begin
            if (wb_sel_i[0]) begin
               st_d.ae_ofs = wb_dat_i[`OFS_AE_LSB +: `CNT_W];
            end
            if (wb_sel_i[1]) begin
               st_d.af_ofs = wb_dat_i[`OFS_AF_LSB +: `CNT_W];
            end
         end else if (!wb_we_i) begin
            unique case ({wb_adr_i[`WB_ADR_W-1:2], 2'b00})
               `ADR_OFFSETS: begin
                  st_d.wb_dat = {19'h00000, st_q.af_ofs, 3'h0, st_q.ae_ofs};
               end
               `ADR_STATUS: begin
                  st_d.wb_dat = {7'h00, st_q.cfg_valid, st_q.cfg,
                                 (st_q.rts == fifo_ctl_pkg::RT_SETUP), st_q.hf_n, st_q.af_n,
                                 st_q.ae_n, st_q.is_n, st_q.ov_n, st_q.ff_n, st_q.ef_n,
                                 3'h0, cnt_cur};
               end
               default: begin
                  st_d.wb_dat = '0;
               end
            endcase
         end
      end

      // Flags follow the next pointer state; sync timing adds one stage to the programmable ones.
      if (!flags_forced) begin
         // In fall-through mode the word in the output register still counts as held for the almost-empty and half-full flags.
         cnt_nxt = st_d.wr_ptr - st_d.rd_ptr;
         total   = {1'b0, cnt_nxt} +
                   {5'h00, (st_q.cfg.fall_through_mode & st_d.out_valid)};
         ae_calc = (total > {1'b0, st_d.ae_ofs});
         af_calc = ((6'(`DEPTH) - {1'b0, cnt_nxt}) > {1'b0, st_d.af_ofs});
         st_d.ae_lvl = ae_calc;
         st_d.af_lvl = af_calc;
         st_d.ae_n   = st_q.cfg.sync_flag_timing ? st_q.ae_lvl : ae_calc;
         st_d.af_n   = st_q.cfg.sync_flag_timing ? st_q.af_lvl : af_calc;
         st_d.hf_n   = !(total > `HALF_LEVEL);
         if (st_q.cfg.fall_through_mode) begin
            st_d.ef_n = 1'b1;
            st_d.ff_n = 1'b1;
            st_d.ov_n = rt_hit || (st_d.rts == fifo_ctl_pkg::RT_SETUP) ||
                        !st_d.out_valid;
            st_d.is_n = (cnt_nxt == `CNT_W'(`DEPTH));
         end else begin
            st_d.ov_n = 1'b1;
            st_d.is_n = 1'b1;
            st_d.ef_n = !(rt_hit || (st_d.rts == fifo_ctl_pkg::RT_SETUP) ||
                          (cnt_nxt == '0));
            st_d.ff_n = (cnt_nxt != `CNT_W'(`DEPTH));
         end
         // Until configured, the programmable flags keep their reset levels.
         if (!st_q.cfg_valid) begin
            st_d.ae_n = 1'b0;
            st_d.af_n = 1'b1;
            st_d.hf_n = 1'b1;
         end
      end else begin
         st_d.ae_lvl = 1'b0;
         st_d.af_lvl = 1'b1;
      end
   end

   // Reset leaves the block unconfigured; nothing is stored or read until a master
   // reset has come through the synchroniser.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_q        <= '0;
         st_q.ef_n   <= 1'b0;
         st_q.ov_n   <= 1'b1;
         st_q.ff_n   <= 1'b1;
         st_q.is_n   <= 1'b1;
         st_q.af_n   <= 1'b1;
         st_q.hf_n   <= 1'b1;
         st_q.af_lvl <= 1'b1;
         st_q.ae_ofs <= `AE_OFS_DEFAULT;
         st_q.af_ofs <= `AF_OFS_DEFAULT;
      end else begin
         st_q <= st_d;
      end
   end

   assign read_data_out_o  = st_q.dout;
   assign empty_flag_n_o   = st_q.ef_n;
   assign output_valid_n_o = st_q.ov_n;
   assign full_flag_n_o    = st_q.ff_n;
   assign input_space_n_o  = st_q.is_n;
   assign almost_empty_n_o = st_q.ae_n;
   assign almost_full_n_o  = st_q.af_n;
   assign half_full_n_o    = st_q.hf_n;
   assign wb_dat_o         = st_q.wb_dat;
   assign wb_ack_o         = st_q.wb_ack;

endmodule : fifo_reset_retransmit_control

// [dv/fifo_ctl_checker.sv]
// Port assertions for the FIFO reset and retransmit controller.
`timescale 1ns/1ps
`include "fifo_ctl_defs.svh"
module fifo_ctl_checker (
   input wire logic               clk_i,
   input wire logic               rst_i,
   input wire logic               master_reset_n_i,
   input wire logic               partial_reset_n_i,
   input wire logic               retransmit_n_i,
   input wire logic               wb_cyc_i,
   input wire logic               wb_stb_i,
   input wire logic [`DATA_W-1:0] read_data_out_o,
   input wire logic               empty_flag_n_o,
   input wire logic               output_valid_n_o,
   input wire logic               full_flag_n_o,
   input wire logic               input_space_n_o,
   input wire logic               almost_empty_n_o,
   input wire logic               almost_full_n_o,
   input wire logic               half_full_n_o,
   input wire logic               wb_ack_o
);
   logic rst_look;
   assign rst_look = read_data_out_o == '0 && !almost_empty_n_o && almost_full_n_o
                     && half_full_n_o && full_flag_n_o && output_valid_n_o;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   sequence s_mr; !master_reset_n_i [*3]; endsequence
   sequence s_pr; !partial_reset_n_i [*3]; endsequence
   sequence s_rt; !retransmit_n_i [*3]; endsequence
   property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
   a_ack_once: assert property (p_ack_once) else $error("ack held too long");
   property p_ack_lat; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
   a_ack_lat: assert property (p_ack_lat) else $error("ack late");
   property p_mr; s_mr |=> rst_look; endproperty
   a_mr: assert property (p_mr) else $error("master reset state wrong");
   property p_pr; s_pr |=> rst_look; endproperty
   a_pr: assert property (p_pr) else $error("partial reset state wrong");
   property p_rt; s_rt |=> output_valid_n_o; endproperty
   a_rt: assert property (p_rt) else $error("retransmit not marked");
   property p_mode_ef; !(!empty_flag_n_o && !output_valid_n_o); endproperty
   a_mode_ef: assert property (p_mode_ef) else $error("both read flags low");
   property p_mode_ff; !(!full_flag_n_o && !input_space_n_o); endproperty
   a_mode_ff: assert property (p_mode_ff) else $error("both write flags low");
   property p_full; !full_flag_n_o |-> !half_full_n_o ##[0:1] !almost_full_n_o; endproperty
   a_full: assert property (p_full) else $error("full without other flags");
endmodule : fifo_ctl_checker
bind fifo_reset_retransmit_control fifo_ctl_checker u_chk (.clk_i, .rst_i, .master_reset_n_i,
   .partial_reset_n_i, .retransmit_n_i, .wb_cyc_i, .wb_stb_i, .read_data_out_o,
   .empty_flag_n_o, .output_valid_n_o, .full_flag_n_o, .input_space_n_o,
   .almost_empty_n_o, .almost_full_n_o, .half_full_n_o, .wb_ack_o);

// [dv/fifo_writer_model.sv]
// Writer-side model that feeds words into the FIFO write port.
`timescale 1ns/1ps
`include "fifo_ctl_defs.svh"
module fifo_writer_model (
   input  wire logic               clk_i,
   input  wire logic               master_reset_n_i,
   input  wire logic               retransmit_n_i,
   input  wire logic               req_i,
   input  wire logic [`DATA_W-1:0] dat_i,
   output logic                    write_enable_n_o,
   output logic      [`DATA_W-1:0] write_data_o
);
   logic seen_mr_q;
   initial {seen_mr_q, write_enable_n_o, write_data_o} = {2'b01, 18'h00000};
   always @(posedge clk_i) begin
      if (!master_reset_n_i) seen_mr_q <= 1'b1;
      if (req_i && seen_mr_q && retransmit_n_i) begin
         write_enable_n_o <= 1'b0;
         write_data_o     <= dat_i;
      end else begin
         write_enable_n_o <= 1'b1;
         write_data_o     <= ~write_data_o;
      end
   end
endmodule : fifo_writer_model

// [dv/testbench.sv]
// Self-checking testbench for the FIFO reset and retransmit controller.
`timescale 1ns/1ps
`include "fifo_ctl_defs.svh"
module testbench;
   logic clk_i, rst_i, req, we_n, cyc, stb, we, ack;
   logic ef_n, ov_n, ff_n, is_n, ae_n, af_n, hf_n;
   logic [17:0] dat, wd, q;
   logic [7:0]  adr;
   logic [31:0] wdat, rdat, r;
   int          n_mismatch = 0;
   int          total_checks = 0;
   fifo_ctl_pkg::pins_t p;
   fifo_writer_model u_wr (.clk_i(clk_i), .master_reset_n_i(p.master_reset_n),
      .retransmit_n_i(p.retransmit_n), .req_i(req), .dat_i(dat),
      .write_enable_n_o(we_n), .write_data_o(wd));
   fifo_reset_retransmit_control dut (.clk_i(clk_i), .rst_i(rst_i),
      .master_reset_n_i(p.master_reset_n), .partial_reset_n_i(p.partial_reset_n),
      .write_enable_n_i(we_n), .read_enable_n_i(p.read_enable_n),
      .retransmit_n_i(p.retransmit_n), .serial_load_enable_n_i(p.serial_load_enable_n),
      .offset_load_n_i(p.offset_load_n),
      .fallthrough_select_serial_in_i(p.fallthrough_select_serial_in),
      .read_port_width_i(p.read_port_width), .write_port_width_i(p.write_port_width),
      .byte_order_select_i(p.byte_order_select),
      .retransmit_latency_select_i(p.retransmit_latency_select),
      .flag_timing_select_i(p.flag_timing_select),
      .parity_interleave_select_i(p.parity_interleave_select), .write_data_i(wd),
      .read_data_out_o(q), .empty_flag_n_o(ef_n), .output_valid_n_o(ov_n),
      .full_flag_n_o(ff_n), .input_space_n_o(is_n), .almost_empty_n_o(ae_n),
      .almost_full_n_o(af_n), .half_full_n_o(hf_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack));
   task automatic cyc_n(input int n);
      repeat (n) @(posedge clk_i);
   endtask : cyc_n
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Classic cycle: request holds until ack is sampled high, then released.
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
      do @(posedge clk_i); while (ack !== 1'b1);
      r = rdat;
      {cyc, stb} <= 2'b00;
      @(posedge clk_i);
   endtask : wb
   task automatic mreset(input logic [4:0] s);
      {p.fallthrough_select_serial_in, p.retransmit_latency_select, p.read_port_width,
       p.flag_timing_select, p.byte_order_select} <= s;
      p.master_reset_n <= 1'b0;
      cyc_n(4);
      p.master_reset_n <= 1'b1;
      cyc_n(4);
   endtask : mreset
   task automatic push(input logic [17:0] d);
      {req, dat} <= {1'b1, d};
      cyc_n(1);
   endtask : push
   task automatic rd();
      p.read_enable_n <= 1'b0;
      cyc_n(1);
      p.read_enable_n <= 1'b1;
      cyc_n(4);
   endtask : rd
   task automatic rt();
      p.retransmit_n <= 1'b0;
      cyc_n(3);
      p.retransmit_n <= 1'b1;
      cyc_n(1);
   endtask : rt
   task automatic stop_test();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : stop_test
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end
   initial begin
      cyc_n(3000);
      n_mismatch++;
      stop_test();
   end
   initial begin
      {rst_i, req, dat, cyc, stb, we, adr, wdat, p} = '0;
      rst_i = 1'b1;
      {p.master_reset_n, p.partial_reset_n, p.read_enable_n, p.retransmit_n,
       p.serial_load_enable_n, p.offset_load_n} = '1;
      cyc_n(2);
      rst_i <= 1'b0;
      cyc_n(3);
      mreset(5'b01000);
      wb(0, 8'h04, 0);
      chk(r, 32'h01096E00);
      wb(1, 8'h00, 32'h00000503);
      for (int i = 1; i <= 17; i++) push(18'(i));
      req <= 1'b0;
      cyc_n(6);
      chk(ff_n, 0);
      chk({ae_n, af_n, hf_n}, 3'b100);
      rd();
      chk(q, 18'h00001);
      rd();
      rt();
      chk(ef_n, 0);
      cyc_n(3);
      chk(ef_n, 0);
      cyc_n(3);
      chk(ef_n, 1);
      rd();
      chk(q, 18'h00001);
      p.partial_reset_n <= 1'b0;
      cyc_n(4);
      p.partial_reset_n <= 1'b1;
      cyc_n(4);
      chk(q, 18'h00000);
      wb(0, 8'h04, 0);
      chk(r, 32'h01096E00);
      wb(0, 8'h00, 0);
      chk(r, 32'h00000503);
      wb(0, 8'h08, 0);
      chk(r, 32'h00000000);
      $display("standard mode test done");
      mreset(5'b10111);
      wb(0, 8'h04, 0);
      chk(r, 32'h01D56700);
      push(18'h3FFFF);
      push(18'h00055);
      req <= 1'b0;
      cyc_n(10);
      chk(q, 18'h001FF);
      chk({ov_n, is_n}, 2'b00);
      rd();
      chk(q, 18'h00055);
      rt();
      chk(q, 18'h001FF);
      cyc_n(3);
      chk(ov_n, 0);
      p.offset_load_n <= 1'b0;
      for (int i = 9; i >= 0; i--) begin
         p.serial_load_enable_n         <= 1'b0;
         p.fallthrough_select_serial_in <= 1'(10'h0C4 >> i);
         cyc_n(1);
      end
      p.serial_load_enable_n <= 1'b1;
      rd();
      chk(q, 18'h00004);
      p.offset_load_n <= 1'b1;
      wb(0, 8'h00, 0);
      chk(r, 32'h00000604);
      $display("fall-through test done");
      stop_test();
   end
endmodule : testbench
